/* File: ascc_pkg.sv */
package ascc_pkg;

    localparam int ADDR_W = 4;
    localparam int RES_W = 10;
    localparam int NUM_SRC = 14;
    localparam int FALL_W = 5;
    localparam int ADDR_CLKS = 4;
    localparam int HOLD_CLK = 10;
    localparam int XFER_CLKS = 16;
    // falls already seen when the eleventh rising edge arrives
    localparam int RISE_CHK_FALLS = 10;

    // highest external source code, then the self-test source codes
    localparam logic [3:0] ADDR_EXT_MAX = 4'ha;
    localparam logic [3:0] ADDR_MID = 4'hb;
    localparam logic [3:0] ADDR_LO = 4'hc;
    localparam logic [3:0] ADDR_HI = 4'hd;

    localparam logic [9:0] SAR_FIRST = 10'h200;
    localparam logic [9:0] RESULT_RST = 10'h000;

    localparam real CLK_PERIOD_NS = 8.0;
    localparam real T_RISE11_US = 9.5;
    // longest time, so round down
    localparam int RISE11_CYC = $rtoi(T_RISE11_US * 1000.0 / CLK_PERIOD_NS);
    // ten trials end before the eleventh-edge limit runs out
    localparam int TRIAL_CYC = RISE11_CYC / RES_W;
    localparam int CS_GUARD_CYC = 2;

    typedef enum logic [1:0] {
        SQ_IDLE = 2'b00,
        SQ_GUARD = 2'b01,
        SQ_XFER = 2'b10,
        SQ_LOST = 2'b11
    } ascc_seq_t;

    typedef enum logic {
        CV_IDLE = 1'b0,
        CV_RUN = 1'b1
    } ascc_conv_t;

    typedef struct packed {
        logic fall_tgl;
        logic rise11_tgl;
    } ascc_evt_t;

endpackage

/* File: ascc_sync2.sv */
`timescale 1ns/1ps
module ascc_sync2 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [W-1:0] d_in,
    output logic [W-1:0] q_out
);

    logic [W-1:0] meta_q;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            meta_q <= RST_VAL;
            q_out <= RST_VAL;
        end else begin
            meta_q <= d_in;
            q_out <= meta_q;
        end
    end

endmodule // ascc_sync2

/* File: ascc_ctrl.sv */
`timescale 1ns/1ps
module ascc_ctrl #(
    parameter int TRIAL_CYC = ascc_pkg::TRIAL_CYC
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic io_clk_in,
    input wire logic cs_n_in,
    input wire logic addr_in,
    input wire logic comp_above_in,
    output logic data_out,
    output logic data_oe_n_out,
    output logic eoc_out,
    output logic sample_out,
    output logic [ascc_pkg::NUM_SRC-1:0] chan_sel_out,
    output logic [ascc_pkg::RES_W-1:0] trial_out,
    output logic sync_lost_out
);
    localparam int STEP_W = $clog2(TRIAL_CYC + 1);
    localparam int RW = ascc_pkg::RES_W;
    // the select pin clears this side, since the serial clock stands still between frames
    logic [ascc_pkg::FALL_W-1:0] lk_falls_q;
    logic [ascc_pkg::ADDR_W-1:0] lk_addr_q;
    logic lk_fall_tgl_q;
    logic lk_rise_tgl_q;
    ascc_pkg::ascc_evt_t lk_evt;
    always_ff @(negedge io_clk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            lk_falls_q <= '0;
            lk_fall_tgl_q <= 1'b0;
        end else begin
            lk_fall_tgl_q <= ~lk_fall_tgl_q;
            if (lk_falls_q == ascc_pkg::FALL_W'(ascc_pkg::XFER_CLKS - 1)) begin
                lk_falls_q <= '0;
            end else begin
                lk_falls_q <= lk_falls_q + 5'h1;
            end
        end
    end
    always_ff @(posedge io_clk_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            lk_addr_q <= '0;
            lk_rise_tgl_q <= 1'b0;
        end else begin
            if (lk_falls_q < ascc_pkg::FALL_W'(ascc_pkg::ADDR_CLKS)) begin
                lk_addr_q <= {lk_addr_q[ascc_pkg::ADDR_W-2:0], addr_in};
            end
            if (lk_falls_q == ascc_pkg::FALL_W'(ascc_pkg::RISE_CHK_FALLS)) begin
                lk_rise_tgl_q <= ~lk_rise_tgl_q;
            end
        end
    end
    assign lk_evt = '{fall_tgl: lk_fall_tgl_q, rise11_tgl: lk_rise_tgl_q};
    logic cs_s;
    logic comp_s;
    ascc_pkg::ascc_evt_t evt_s;
    ascc_sync2 #(.W(1), .RST_VAL(1'b1)) u_cs_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(cs_n_in),
        .q_out(cs_s)
    );
    ascc_sync2 #(.W($bits(ascc_pkg::ascc_evt_t)), .RST_VAL('0)) u_evt_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(lk_evt),
        .q_out(evt_s)
    );
    ascc_sync2 #(.W(1), .RST_VAL(1'b0)) u_comp_sync (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .d_in(comp_above_in),
        .q_out(comp_s)
    );
    logic cs_prev_q;
    ascc_pkg::ascc_evt_t evt_prev_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cs_prev_q <= 1'b1;
            evt_prev_q <= '0;
        end else begin
            cs_prev_q <= cs_s;
            evt_prev_q <= evt_s;
        end
    end
    logic cs_fall;
    logic cs_rise;
    logic fall_ev;
    logic rise_ev;
    assign cs_fall = cs_prev_q & ~cs_s;
    assign cs_rise = ~cs_prev_q & cs_s;
    assign fall_ev = evt_s.fall_tgl ^ evt_prev_q.fall_tgl;
    assign rise_ev = evt_s.rise11_tgl ^ evt_prev_q.rise11_tgl;
    ascc_pkg::ascc_seq_t seq_q;
    logic [1:0] guard_q;
    logic [ascc_pkg::FALL_W-1:0] fall_num_q;
    ascc_pkg::ascc_conv_t cv_q;
    logic [3:0] bit_idx_q;
    logic [STEP_W-1:0] step_q;
    logic [RW-1:0] sar_q;
    logic [RW-1:0] result_q;
    logic [RW-1:0] out_sh_q;
    logic rise_seen_q;
    logic [ascc_pkg::NUM_SRC-1:0] chan_next_q;
    logic mux_pend_q;
    logic xfer_fall;
    logic fall4;
    logic fall10;
    logic fall16;
    logic trial_end;
    logic conv_done;
    logic sync_loss;
    assign xfer_fall = (seq_q == ascc_pkg::SQ_XFER) && fall_ev;
    assign fall4 = xfer_fall && (fall_num_q == ascc_pkg::FALL_W'(ascc_pkg::ADDR_CLKS - 1));
    assign fall10 = xfer_fall && (fall_num_q == ascc_pkg::FALL_W'(ascc_pkg::HOLD_CLK - 1));
    assign fall16 = xfer_fall && (fall_num_q == ascc_pkg::FALL_W'(ascc_pkg::XFER_CLKS - 1));
    assign trial_end = (cv_q == ascc_pkg::CV_RUN) && (step_q == STEP_W'(TRIAL_CYC - 1));
    assign conv_done = trial_end && (bit_idx_q == 4'h0);
    // conversion finished while the eleventh rise is still missing
    assign sync_loss = conv_done && (seq_q == ascc_pkg::SQ_XFER) && !rise_seen_q && !rise_ev;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            seq_q <= ascc_pkg::SQ_IDLE;
            guard_q <= 2'h0;
            fall_num_q <= '0;
            sync_lost_out <= 1'b0;
        end else if (cs_rise) begin
            seq_q <= ascc_pkg::SQ_IDLE;
            sync_lost_out <= 1'b0;
        end else if (cs_fall) begin
            seq_q <= ascc_pkg::SQ_GUARD;
            sync_lost_out <= 1'b0;
            guard_q <= 2'h0;
            fall_num_q <= '0;
        end else begin
            unique case (seq_q)
                ascc_pkg::SQ_IDLE: begin
                end
                ascc_pkg::SQ_GUARD: begin
                    // noise guard on the select line before clocks count
                    guard_q <= guard_q + 2'h1;
                    if (guard_q == 2'(ascc_pkg::CS_GUARD_CYC - 1)) begin
                        seq_q <= ascc_pkg::SQ_XFER;
                    end
                end
                ascc_pkg::SQ_XFER: begin
                    if (sync_loss) begin
                        seq_q <= ascc_pkg::SQ_LOST;
                        sync_lost_out <= 1'b1;
                    end else if (fall16) begin
                        fall_num_q <= '0;
                    end else if (fall_ev) begin
                        fall_num_q <= fall_num_q + 5'h1;
                    end
                end
                ascc_pkg::SQ_LOST: begin
                end
            endcase
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            rise_seen_q <= 1'b0;
        end else if (cs_fall || fall10) begin
            rise_seen_q <= 1'b0;
        end else if (rise_ev && seq_q == ascc_pkg::SQ_XFER) begin
            rise_seen_q <= 1'b1;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            data_oe_n_out <= 1'b1;
            data_out <= 1'b0;
            out_sh_q <= '0;
        end else if (cs_rise) begin
            data_oe_n_out <= 1'b1;
        end else if (cs_fall) begin
            data_oe_n_out <= 1'b0;
            data_out <= result_q[RW-1];
            out_sh_q <= result_q;
        end else if (xfer_fall) begin
            if (fall16) begin
                data_out <= result_q[RW-1];
                out_sh_q <= result_q;
            end else if (fall_num_q >= ascc_pkg::FALL_W'(ascc_pkg::HOLD_CLK - 1)) begin
                data_out <= 1'b0;
            end else begin
                data_out <= out_sh_q[RW-2];
                out_sh_q <= {out_sh_q[RW-2:0], 1'b0};
            end
        end
    end
    // address word is stable from the fourth rise, read only on the synced fourth fall
    logic [ascc_pkg::NUM_SRC-1:0] chan_dec;
    genvar g;
    generate
        for (g = 0; g < ascc_pkg::NUM_SRC; g++) begin : g_dec
            assign chan_dec[g] = (lk_addr_q == ascc_pkg::ADDR_W'(g));
        end
    endgenerate
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            chan_sel_out <= '0;
            chan_next_q <= '0;
            mux_pend_q <= 1'b0;
        end else if (fall4) begin
            chan_next_q <= chan_dec;
            if (chan_sel_out != chan_dec) begin
                chan_sel_out <= '0;
                mux_pend_q <= 1'b1;
            end
        end else if (mux_pend_q) begin
            chan_sel_out <= chan_next_q;
            mux_pend_q <= 1'b0;
        end
    end
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            sample_out <= 1'b0;
        end else if (cs_fall || fall10) begin
            sample_out <= 1'b0;
        end else if (fall4) begin
            sample_out <= 1'b1;
        end
    end
    // an input past either reference drives every trial the same way, so the
    // result pins at all zeros or all ones without a separate clamp
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cv_q <= ascc_pkg::CV_IDLE;
            sar_q <= '0;
            bit_idx_q <= 4'h0;
            step_q <= '0;
        end else if (cs_fall) begin
            cv_q <= ascc_pkg::CV_IDLE;
            sar_q <= '0;
        end else if (fall10) begin
            cv_q <= ascc_pkg::CV_RUN;
            sar_q <= ascc_pkg::SAR_FIRST;
            bit_idx_q <= 4'(RW - 1);
            step_q <= '0;
        end else if (cv_q == ascc_pkg::CV_RUN) begin
            if (trial_end) begin
                step_q <= '0;
                if (comp_s) begin
                    sar_q[bit_idx_q] <= 1'b0;
                end
                if (bit_idx_q == 4'h0) begin
                    cv_q <= ascc_pkg::CV_IDLE;
                end else begin
                    bit_idx_q <= bit_idx_q - 4'h1;
                    sar_q[bit_idx_q - 4'h1] <= 1'b1;
                end
            end else begin
                step_q <= step_q + STEP_W'(1);
            end
        end
    end
    assign trial_out = sar_q;
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            eoc_out <= 1'b1;
            result_q <= ascc_pkg::RESULT_RST;
        end else if (cs_fall) begin
            eoc_out <= 1'b1;
        end else if (fall10) begin
            eoc_out <= 1'b0;
        end else if (conv_done) begin
            eoc_out <= 1'b1;
            result_q <= {sar_q[RW-1:1], ~comp_s};
        end
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);

    chk_select_enables: assert property (cs_fall |=> !data_oe_n_out && data_out == $past(result_q[RW-1]))
        else $error("output not enabled with msb after select fall");
    chk_deselect_floats: assert property (cs_rise |=> data_oe_n_out ##1 $stable(fall_num_q))
        else $error("output not floated after select rise");
    chk_mode6_restart: assert property (fall16 && !cs_rise |=> fall_num_q == 5'h0 && data_out == $past(result_q[RW-1]))
        else $error("sixteenth fall did not restart with msb");
    chk_mux_break: assert property ($past(chan_sel_out) != '0 && $changed(chan_sel_out) |-> chan_sel_out == '0)
        else $error("mux switched without break");
    chk_midpoint_code: assert property (fall4 && lk_addr_q == ascc_pkg::ADDR_MID |=> chan_next_q[11])
        else $error("midpoint self-test not decoded");
    chk_sample_window: assert property (fall4 && !cs_fall |=> sample_out)
        else $error("sampling did not start at fourth fall");
    chk_hold_start: assert property (fall10 && !cs_rise && !cs_fall
        |=> !sample_out && !eoc_out && sar_q == ascc_pkg::SAR_FIRST && !data_out)
        else $error("tenth fall did not hold and start conversion");
    chk_trial_drop: assert property (trial_end && comp_s && bit_idx_q != 4'h0 && !cs_fall
        |=> !sar_q[$past(bit_idx_q)] && sar_q[$past(bit_idx_q) - 4'h1])
        else $error("trial bit not dropped on comparator high");
    chk_abort_keeps: assert property (cs_fall |=> cv_q == ascc_pkg::CV_IDLE && eoc_out && $stable(result_q))
        else $error("abort did not keep previous result");
    chk_eoc_done: assert property (conv_done && !cs_fall |=> eoc_out ##1 eoc_out)
        else $error("end of conversion not raised when done");
    chk_lost_sync: assert property (sync_loss && !cs_rise && !cs_fall |=> sync_lost_out)
        else $error("late eleventh edge not flagged");

    cov_mode5_frame: cover property (conv_done ##[1:300] cs_rise);
    cov_mode6_loop: cover property (fall16);
    cov_abort: cover property (cv_q == ascc_pkg::CV_RUN && cs_fall);
    cov_sync_lost: cover property (sync_loss);

endmodule // ascc_ctrl

/* File: ascc_host.sv */
`timescale 1ns/1ps
module ascc_host (
    output logic io_clk_out,
    output logic cs_n_out,
    output logic addr_out,
    input wire logic data_in,
    input wire logic data_oe_n_in
);
    localparam real HALF_NS = 80.0;

    // the serial clock stands low between frames
    initial begin
        io_clk_out = 1'b0;
        cs_n_out = 1'b1;
        addr_out = 1'b0;
    end

    // bits come back left aligned: the first sampled bit lands in [15]
    task automatic xfer(input logic [3:0] a, input int nclk, input bit drop, input bit raise, input real gap10_ns,
                        output logic [15:0] bits, output logic oe_n_first);
        bits = 16'h0000;
        oe_n_first = 1'b1;
        if (drop) begin
            cs_n_out = 1'b0;
            // the device ignores clocks during its select guard
            #200.3;
        end
        for (int k = 1; k <= nclk; k++) begin
            addr_out = (k <= 4) ? a[4 - k] : ~addr_out;
            #(HALF_NS) io_clk_out = 1'b1;
            bits = {bits[14:0], data_in};
            if (k == 1) begin
                oe_n_first = data_oe_n_in;
            end
            #(HALF_NS) io_clk_out = 1'b0;
            if (k == 10) begin
                #(gap10_ns);
            end
        end
        bits = bits << (16 - nclk);
        if (raise) begin
            cs_high();
        end
    endtask

    task automatic cs_high();
        #(HALF_NS) cs_n_out = 1'b1;
        #400;
    endtask

    // select raised and dropped again by about the middle of the conversion, well clear of its end
    task automatic cs_pulse();
        #(HALF_NS) cs_n_out = 1'b1;
        #(HALF_NS) cs_n_out = 1'b0;
        #(HALF_NS);
    endtask
endmodule // ascc_host

/* File: ascc_ctrl_tb.sv */
`timescale 1ns/1ps
module ascc_ctrl_tb;
    localparam int TRIAL = 4;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic comp_above_in = 1'b0;
    logic io_clk, cs_n, addr, data_line;
    logic data_out, data_oe_n_out, eoc_out, sample_out, sync_lost_out;
    logic [ascc_pkg::NUM_SRC-1:0] chan_sel_out;
    logic [ascc_pkg::NUM_SRC-1:0] sel_seen = '0;
    logic [ascc_pkg::RES_W-1:0] trial_out;
    logic [ascc_pkg::RES_W-1:0] vin_q = 10'h000;
    logic [ascc_pkg::RES_W-1:0] prev_exp = 10'h000;
    logic [1:0] ov = 2'b00;
    logic eoc_low_seen = 1'b0;
    logic [15:0] bits;
    logic oe_n_first;
    int err_total = 0;
    int compares = 0;

    always #4 clk_in = ~clk_in;

    ascc_ctrl #(.TRIAL_CYC(TRIAL)) dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_clk_in(io_clk), .cs_n_in(cs_n),
        .addr_in(addr), .comp_above_in(comp_above_in), .data_out(data_out), .data_oe_n_out(data_oe_n_out),
        .eoc_out(eoc_out), .sample_out(sample_out), .chan_sel_out(chan_sel_out), .trial_out(trial_out),
        .sync_lost_out(sync_lost_out));
    ascc_host host (.io_clk_out(io_clk), .cs_n_out(cs_n), .addr_out(addr), .data_in(data_line),
        .data_oe_n_in(data_oe_n_out));

    // a floating pin shows the inverse so a stale bit never reads as valid
    assign data_line = (data_oe_n_out === 1'b0) ? data_out : ~data_out;

    function automatic logic [9:0] src_val(input int i);
        case (i)
            11: return 10'h200;
            12: return 10'h000;
            13: return 10'h3ff;
            default: return (i < 11) ? 10'h03c + 10'(i) * 10'h05b : 10'h155;
        endcase
    endfunction

    // analog side: held input from the selected source, comparator against the trial word
    always @(posedge clk_in) begin
        if (sample_out === 1'b1) begin
            vin_q <= 10'h155;
            for (int i = 0; i < ascc_pkg::NUM_SRC; i++) begin
                if (chan_sel_out[i] === 1'b1) begin
                    vin_q <= src_val(i);
                end
            end
            sel_seen <= chan_sel_out;
        end
        if (eoc_out === 1'b0) begin
            eoc_low_seen <= 1'b1;
        end
        comp_above_in <= (ov == 2'b01) ? 1'b0 : (ov == 2'b10) ? 1'b1 : (trial_out > vin_q);
    end

    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask

    task automatic run(input logic [3:0] a, input int nclk, input bit drop, input bit raise, input real gap);
        eoc_low_seen = 1'b0;
        host.xfer(a, nclk, drop, raise, gap, bits, oe_n_first);
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        check("oe_n", 16'h1, 16'(data_oe_n_out));
        check("eoc", 16'h1, 16'(eoc_out));
        check("sample", 16'h0, 16'(sample_out));
        check("chan_sel", 16'h0, 16'(chan_sel_out));
        check("sync_lost", 16'h0, 16'(sync_lost_out));
        $display("test reset done");
    endtask

    // every source once, transfer length swept over 11 to 16 clocks
    task automatic t_channels();
        for (int a = 0; a < ascc_pkg::NUM_SRC; a++) begin
            run(4'(a), 11 + a % 6, 1'b1, 1'b0, 0.0);
            check("sel", 16'(14'h1 << a), 16'(sel_seen));
            check("hold", 16'h0, 16'(sample_out));
            check("oe_on", 16'h0, 16'(oe_n_first));
            check("result", {prev_exp, 6'h00}, bits);
            host.cs_high();
            check("trial", 16'(src_val(a)), 16'(trial_out));
            check("oe_off", 16'h1, 16'(data_oe_n_out));
            check("eoc", 16'h3, {14'h0, eoc_low_seen, eoc_out});
            prev_exp = src_val(a);
        end
        $display("test channels done");
    endtask

    task automatic t_saturate();
        ov = 2'b01;
        run(4'h0, 16, 1'b1, 1'b1, 0.0);
        check("result", {prev_exp, 6'h00}, bits);
        ov = 2'b10;
        run(4'h0, 16, 1'b1, 1'b1, 0.0);
        check("sat_hi", {10'h3ff, 6'h00}, bits);
        ov = 2'b00;
        run(4'h0, 16, 1'b1, 1'b1, 0.0);
        check("sat_lo", 16'h0000, bits);
        prev_exp = src_val(0);
        $display("test saturate done");
    endtask

    // select held low: each sixteenth fall restarts and shows the new msb
    task automatic t_mode6();
        logic [3:0] addrs [3] = '{4'h2, 4'h7, 4'h9};
        for (int i = 0; i < 3; i++) begin
            run(addrs[i], 16, i == 0, i == 2, 0.0);
            check("mode6", {prev_exp, 6'h00}, bits);
            prev_exp = src_val(addrs[i]);
        end
        $display("test mode6 done");
    endtask

    task automatic t_abort();
        run(4'h5, 10, 1'b1, 1'b0, 0.0);
        check("result", {prev_exp, 6'h00}, bits);
        host.cs_pulse();
        check("abort_eoc", 16'h1, 16'(eoc_out));
        run(4'h1, 16, 1'b0, 1'b1, 0.0);
        check("abort_keep", {prev_exp, 6'h00}, bits);
        prev_exp = src_val(1);
        $display("test abort done");
    endtask

    // eleventh rise held back past the end of the conversion
    task automatic t_sync();
        run(4'h3, 16, 1'b1, 1'b0, 1000.0);
        check("lost", 16'h1, 16'(sync_lost_out));
        host.cs_high();
        run(4'h0, 16, 1'b1, 1'b1, 0.0);
        check("relock", 16'h0, 16'(sync_lost_out));
        $display("test sync done");
    endtask

    initial begin
        #500000;
        err_total++;
        end_of_test();
    end

    initial begin
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        @(posedge clk_in);
        #1;
        t_reset();
        t_channels();
        t_saturate();
        t_mode6();
        t_abort();
        t_sync();
        end_of_test();
    end
endmodule // ascc_ctrl_tb
